// File: src/dpr_consts.svh
// Offsets, field positions, reset values and key for the power requester.
//
// Contract
// (R01) Reading the acknowledge status register returns the level of each acknowledge input.
// (R02) There is one acknowledge status bit per configured power domain, bit n for input n.
// (R03) Bit 0 of the integration control register enables integration mode; bits 31 to 1 are reserved.
// (R04) The claim tag is four bits wide and the claim-set register reads 1 for each implemented bit.
// (R05) Writing 1 to a claim-set bit sets that claim tag bit; writing 0 leaves it alone.
// (R06) Reading the claim-clear register returns the present claim tag value.
// (R07) Writing 1 to a claim-clear bit clears that claim tag bit; writing 0 leaves it alone.
// (R08) Claim tag bits are plain software storage and change nothing else in the block.
// (R09) A full 32-bit write of the unlock key to the lock access register opens the lock.
// (R10) Any other value written to the lock access register closes the lock.
// (R11) While locked, on-chip writes to every register but the lock access register are denied.
// (R12) Accesses from the external debugger ignore the lock entirely.
// (R13) The lock status register reads all zeros from the external debugger.
// (R14) Lock status bit 1 reads 1 while writes are not permitted from this interface.
// (R15) Lock status bit 0 shows whether a lock exists for this interface; if 0, key writes are ignored.
// (R16) Power requests follow a four-phase handshake per domain that no register write can break.
// (R17) After reset the lock is closed and all claim tag bits are clear.
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH

// Register byte offsets.
`define DPR_OFS_PWR_REQ 12'h000
`define DPR_OFS_PWR_ACK 12'h004
`define DPR_OFS_INTEG_CTRL 12'hf00
`define DPR_OFS_CLAIM_SET 12'hfa0
`define DPR_OFS_CLAIM_CLR 12'hfa4
`define DPR_OFS_LOCK_KEY 12'hfb0
`define DPR_OFS_LOCK_STATUS 12'hfb4

// Field positions and widths.
`define DPR_IME_BIT 0
`define DPR_CLAIM_W 4
`define DPR_LSR_PRESENT_BIT 0
`define DPR_LSR_ACTIVE_BIT 1

// Values.
`define DPR_UNLOCK_KEY 32'hc5acce55
`define DPR_CLAIM_IMPL 4'hf
`define DPR_LOCK_RST 1'b1
`define DPR_CLAIM_RST 4'h0
`define DPR_ALL_STRB 4'hf

`endif

// File: src/dpr_pkg.sv
// Types shared by the power requester register bank.
package dpr_pkg;
  typedef logic [31:0] dpr_word_t;
  typedef logic [11:0] dpr_addr_t;
  typedef logic [3:0] dpr_strb_t;
  typedef enum logic {DPR_BUS_IDLE, DPR_BUS_ANSWER} dpr_bus_state_t;
endpackage : dpr_pkg

// File: src/dpr_hs_if.sv
// Carrier between the register bank and the per-domain handshake guard.
`timescale 1ns/100ps
interface dpr_hs_if #(parameter int N = 8);
  logic [N-1:0] want;
  logic [N-1:0] ack;
  logic [N-1:0] req;
  modport bank (output want, output ack, input req);
  modport guard (input want, input ack, output req);
endinterface : dpr_hs_if

// File: src/dpr_pwr_handshake.sv
// Per-domain guard that moves a power request only when the handshake rests.
`timescale 1ns/100ps
module dpr_pwr_handshake #(
  parameter int N = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Request and acknowledge.
  dpr_hs_if.guard hs
);
  import dpr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // A request may only toggle when it equals its acknowledge, so a pending
  // up or down phase always completes before software can reverse it.
  genvar n;
  generate
    for (n = 0; n < N; n++)
    begin : g_dom
      logic rest;
      assign rest = (hs.req[n] == hs.ack[n]);

      // Follow the wanted value only while the domain is at rest.
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          hs.req[n] <= 1'b0;
        else if (rest)
          hs.req[n] <= hs.want[n]; // R16
      end

      property p_req_moves_at_rest;
        @(posedge clk) disable iff (!rst_n)
          (hs.req[n] != $past(hs.req[n])) |->
            ($past(hs.req[n]) == $past(hs.ack[n]));
      endproperty
      a_req_moves_at_rest: assert property (p_req_moves_at_rest) // R16
        else $error("request changed during an open handshake");

      property p_req_follows;
        @(posedge clk) disable iff (!rst_n)
          (hs.req[n] == hs.ack[n]) && (hs.want[n] != hs.req[n]) |=>
            (hs.req[n] == $past(hs.want[n]));
      endproperty
      a_req_follows: assert property (p_req_follows) // R16
        else $error("request did not follow wanted value at rest");
    end
  endgenerate
endmodule : dpr_pwr_handshake

// File: src/dpr_regs.sv
// APB register bank of the debug power requester with claim tag and lock.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "dpr_consts.svh"
module dpr_regs #(
  parameter int NUM_DOMAINS = 8
) (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire dpr_pkg::dpr_addr_t PADDR,
  input wire dpr_pkg::dpr_word_t PWDATA,
  input wire dpr_pkg::dpr_strb_t PSTRB,
  output dpr_pkg::dpr_word_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Access origin: high for the external debugger port.
  input wire logic DBG_ACCESS,
  // Power domains.
  input wire logic [NUM_DOMAINS-1:0] PWR_ACK,
  output logic [NUM_DOMAINS-1:0] PWR_REQ,
  // Integration mode.
  output logic INTEG_MODE
);
  import dpr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.

  dpr_bus_state_t bus_state;
  logic [NUM_DOMAINS-1:0] req_want;
  logic [`DPR_CLAIM_W-1:0] claim_tag;
  logic lock_active_flag;
  logic integration_mode_enable;

  dpr_hs_if #(.N(NUM_DOMAINS)) hs ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Each hit compares the word address; byte bits are ignored.
  logic hit_req;
  logic hit_ack;
  logic hit_itc;
  logic hit_cset;
  logic hit_cclr;
  logic hit_key;
  logic hit_lsr;
  logic hit_any;
  assign hit_req = ({PADDR[11:2], 2'b00} == `DPR_OFS_PWR_REQ);
  assign hit_ack = ({PADDR[11:2], 2'b00} == `DPR_OFS_PWR_ACK);
  assign hit_itc = ({PADDR[11:2], 2'b00} == `DPR_OFS_INTEG_CTRL);
  assign hit_cset = ({PADDR[11:2], 2'b00} == `DPR_OFS_CLAIM_SET);
  assign hit_cclr = ({PADDR[11:2], 2'b00} == `DPR_OFS_CLAIM_CLR);
  assign hit_key = ({PADDR[11:2], 2'b00} == `DPR_OFS_LOCK_KEY);
  assign hit_lsr = ({PADDR[11:2], 2'b00} == `DPR_OFS_LOCK_STATUS);
  assign hit_any = hit_req | hit_ack | hit_itc | hit_cset | hit_cclr |
    hit_key | hit_lsr;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer qualification.

  // A request is taken in the first access cycle; the write lands on the
  // edge where PREADY is sampled high, exactly when the master completes.
  logic acc_start;
  logic acc_done;
  logic wr_go;
  logic lock_applies;
  logic wr_permit;
  logic wr_ok;
  logic lane0;
  assign acc_start = PSEL && PENABLE && (bus_state == DPR_BUS_IDLE);
  assign acc_done = PSEL && PENABLE && (bus_state == DPR_BUS_ANSWER);
  assign wr_go = acc_done && PWRITE && hit_any;
  // Only on-chip accesses see the lock. // R12
  assign lock_applies = lock_active_flag && !DBG_ACCESS;
  assign wr_permit = !lock_applies || hit_key; // R11
  assign wr_ok = wr_go && wr_permit;
  assign lane0 = PSTRB[0];

  // Key writes count only from the on-chip side, where the lock exists.
  logic key_wr;
  logic key_match;
  assign key_wr = wr_ok && hit_key && !DBG_ACCESS; // R15
  assign key_match = (PWDATA == `DPR_UNLOCK_KEY) &&
    (PSTRB == `DPR_ALL_STRB); // R09

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  dpr_word_t lsr_word;
  dpr_word_t ack_word;
  dpr_word_t req_word;
  dpr_word_t rd_mux;
  // The external debugger sees no lock at all, so it reads zero. // R13
  assign lsr_word = DBG_ACCESS ? 32'h0000_0000 :
    32'({lock_active_flag, 1'b1}); // R14 R15
  assign ack_word = 32'(PWR_ACK); // R01 R02
  assign req_word = 32'(req_want);
  assign rd_mux =
    hit_req ? req_word :
    hit_ack ? ack_word :
    hit_itc ? 32'(integration_mode_enable) : // R03
    hit_cset ? 32'(`DPR_CLAIM_IMPL) : // R04
    hit_cclr ? 32'(claim_tag) : // R06
    hit_lsr ? lsr_word :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane mask for the request register.

  logic [31:0] strb_mask;
  logic [NUM_DOMAINS-1:0] next_want;
  assign strb_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}},
    {8{PSTRB[1]}}, {8{PSTRB[0]}}};
  assign next_want = (req_want & ~strb_mask[NUM_DOMAINS-1:0]) |
    (PWDATA[NUM_DOMAINS-1:0] & strb_mask[NUM_DOMAINS-1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine: one wait cycle, then a single-cycle PREADY.

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      bus_state <= DPR_BUS_IDLE;
    else
    begin
      case (bus_state)
        DPR_BUS_IDLE: if (acc_start) bus_state <= DPR_BUS_ANSWER;
        DPR_BUS_ANSWER: bus_state <= DPR_BUS_IDLE;
        default: bus_state <= DPR_BUS_IDLE;
      endcase
    end
  end

  // Answer outputs come from flops; read data is frozen with PREADY.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= acc_start;
      PSLVERR <= acc_start && !hit_any;
      if (acc_start)
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable state.

  // Claim bits drive nothing but read data; they only record ownership. R08
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      claim_tag <= `DPR_CLAIM_RST; // R17
    else if (wr_ok && lane0 && hit_cset)
      claim_tag <= claim_tag | PWDATA[`DPR_CLAIM_W-1:0]; // R05
    else if (wr_ok && lane0 && hit_cclr)
      claim_tag <= claim_tag & ~PWDATA[`DPR_CLAIM_W-1:0]; // R07
  end

  // Lock follows every on-chip key write; any wrong value relocks.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      lock_active_flag <= `DPR_LOCK_RST; // R17
    else if (key_wr)
      lock_active_flag <= !key_match; // R09 R10
  end

  // Integration mode enable and the wanted request pattern.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      integration_mode_enable <= 1'b0;
      req_want <= '0;
    end
    else
    begin
      if (wr_ok && lane0 && hit_itc)
        integration_mode_enable <= PWDATA[`DPR_IME_BIT]; // R03
      if (wr_ok && hit_req)
        req_want <= next_want; // R16
    end
  end

  // Output flop for the integration mode level.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      INTEG_MODE <= 1'b0;
    else
      INTEG_MODE <= integration_mode_enable; // R03
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake guard; requests leave through its flops.

  assign hs.want = req_want;
  assign hs.ack = PWR_ACK;
  assign PWR_REQ = hs.req;

  dpr_pwr_handshake #(.N(NUM_DOMAINS)) u_guard (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .hs(hs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic rd_start;
  assign rd_start = acc_start && !PWRITE;

  property p_ack_read;
    @(posedge SYS_CLK) disable iff (!RST_N)
      rd_start && hit_ack |=>
        PREADY && (PRDATA == 32'($past(PWR_ACK)));
  endproperty
  a_ack_read: assert property (p_ack_read) // R01
    else $error("ack status read wrong");

  property p_ack_upper_zero;
    @(posedge SYS_CLK) disable iff (!RST_N)
      rd_start && hit_ack |=> ((PRDATA >> NUM_DOMAINS) == 32'h0);
  endproperty
  a_ack_upper_zero: assert property (p_ack_upper_zero) // R02
    else $error("ack status bits beyond domain count set");

  property p_ime_write;
    @(posedge SYS_CLK) disable iff (!RST_N)
      wr_ok && lane0 && hit_itc |=> ##1
        (INTEG_MODE == $past(PWDATA[`DPR_IME_BIT], 2));
  endproperty
  a_ime_write: assert property (p_ime_write) // R03
    else $error("integration mode did not follow write");

  property p_cset_read;
    @(posedge SYS_CLK) disable iff (!RST_N)
      rd_start && hit_cset |=> (PRDATA == 32'h0000_000f);
  endproperty
  a_cset_read: assert property (p_cset_read) // R04
    else $error("claim set read not all implemented");

  property p_claim_set;
    @(posedge SYS_CLK) disable iff (!RST_N)
      wr_ok && lane0 && hit_cset |=>
        (claim_tag == ($past(claim_tag) | $past(PWDATA[3:0])));
  endproperty
  a_claim_set: assert property (p_claim_set) // R05
    else $error("claim set write wrong");

  property p_cclr_read;
    @(posedge SYS_CLK) disable iff (!RST_N)
      rd_start && hit_cclr |=> (PRDATA == 32'($past(claim_tag)));
  endproperty
  a_cclr_read: assert property (p_cclr_read) // R06
    else $error("claim clear read does not show tag");

  property p_claim_clr;
    @(posedge SYS_CLK) disable iff (!RST_N)
      wr_ok && lane0 && hit_cclr |=>
        (claim_tag == ($past(claim_tag) & ~$past(PWDATA[3:0])));
  endproperty
  a_claim_clr: assert property (p_claim_clr) // R07
    else $error("claim clear write wrong");

  property p_claim_quiet;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (claim_tag != $past(claim_tag)) |->
        $past(wr_ok && (hit_cset || hit_cclr));
  endproperty
  a_claim_quiet: assert property (p_claim_quiet) // R08
    else $error("claim tag changed without a claim write");

  property p_unlock;
    @(posedge SYS_CLK) disable iff (!RST_N)
      key_wr && key_match |=> !lock_active_flag &&
        (lsr_word[`DPR_LSR_ACTIVE_BIT] == 1'b0);
  endproperty
  a_unlock: assert property (p_unlock) // R09
    else $error("unlock key did not open lock");

  property p_relock;
    @(posedge SYS_CLK) disable iff (!RST_N)
      key_wr && !key_match |=> lock_active_flag;
  endproperty
  a_relock: assert property (p_relock) // R10
    else $error("wrong key did not close lock");

  property p_denied;
    @(posedge SYS_CLK) disable iff (!RST_N)
      wr_go && lock_active_flag && !DBG_ACCESS && !hit_key |=>
        $stable(claim_tag) && $stable(req_want) &&
        $stable(integration_mode_enable);
  endproperty
  a_denied: assert property (p_denied) // R11
    else $error("locked on-chip write changed a register");

  property p_ext_free;
    @(posedge SYS_CLK) disable iff (!RST_N)
      wr_go && DBG_ACCESS && lane0 && hit_cset |=>
        (claim_tag == ($past(claim_tag) | $past(PWDATA[3:0])));
  endproperty
  a_ext_free: assert property (p_ext_free) // R12
    else $error("external write blocked by lock");

  property p_ext_key_ignored;
    @(posedge SYS_CLK) disable iff (!RST_N)
      wr_go && DBG_ACCESS && hit_key |=> $stable(lock_active_flag);
  endproperty
  a_ext_key_ignored: assert property (p_ext_key_ignored) // R15
    else $error("external key write altered lock");

  property p_lsr_ext;
    @(posedge SYS_CLK) disable iff (!RST_N)
      rd_start && hit_lsr && DBG_ACCESS |=> (PRDATA == 32'h0);
  endproperty
  a_lsr_ext: assert property (p_lsr_ext) // R13
    else $error("external lock status read not zero");

  property p_lsr_local;
    @(posedge SYS_CLK) disable iff (!RST_N)
      rd_start && hit_lsr && !DBG_ACCESS |=>
        (PRDATA == {30'h0, $past(lock_active_flag), 1'b1});
  endproperty
  a_lsr_local: assert property (p_lsr_local) // R14
    else $error("on-chip lock status read wrong");

  property p_reset_state;
    @(posedge SYS_CLK)
      !RST_N |=> lock_active_flag && (claim_tag == 4'h0);
  endproperty
  a_reset_state: assert property (p_reset_state) // R17
    else $error("reset did not lock and clear claims");

  property p_answer_once;
    @(posedge SYS_CLK) disable iff (!RST_N)
      acc_start |=> PREADY ##1 !PREADY;
  endproperty
  a_answer_once: assert property (p_answer_once)
    else $error("ready pulse malformed");
endmodule : dpr_regs

// File: bench/dpr_pwr_partner.sv
// Behavioural model of the power domain controllers facing the requester.
`timescale 1ns/100ps
module dpr_pwr_partner #(
  parameter int N = 6
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Handshake with the requester.
  input wire logic [N-1:0] req,
  output logic [N-1:0] ack,
  // High to stall every domain, as a slow controller would.
  input wire logic hold
);
  ////////////////////////////////////////////////////////////////////////////
  // Each acknowledge copies its request one cycle later, or waits while held.
  // It only ever moves towards the request level, so a stalled domain shows
  // the requester an unanswered phase for as long as the bench wants.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ack <= '0;
    else if (!hold)
      ack <= req;
  end
endmodule : dpr_pwr_partner

// File: bench/tb_top.sv
// Self-checking bench for the power requester register bank.
`timescale 1ns/100ps
`include "dpr_consts.svh"
module tb_top;
  import dpr_pkg::*;
  localparam int ND = 6;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  dpr_addr_t paddr = 12'h000;
  dpr_word_t pwdata = 32'h0;
  dpr_strb_t pstrb = 4'h0;
  dpr_strb_t strb_mode = 4'hf;
  dpr_word_t prdata;
  logic pready;
  logic pslverr;
  logic dbg = 1'b0;
  logic dbg_mode = 1'b0;
  logic hold = 1'b0;
  logic [ND-1:0] pwr_ack;
  logic [ND-1:0] pwr_req;
  logic integ_mode;
  dpr_word_t rdv;
  logic errv;
  int n_fail = 0;
  int check_count = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  always #5 clk = ~clk;

  // Design and the domain controllers behind it; writes use strb_mode.
  dpr_regs #(.NUM_DOMAINS(ND)) dut (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DBG_ACCESS(dbg), .PWR_ACK(pwr_ack), .PWR_REQ(pwr_req),
    .INTEG_MODE(integ_mode));
  dpr_pwr_partner #(.N(ND)) partner (
    .clk(clk), .rst_n(rst_n), .req(pwr_req), .ack(pwr_ack), .hold(hold));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic conclude();
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // Word comparison; flags are zero-extended by the caller.
  task automatic chk(input dpr_word_t got, input dpr_word_t exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until PREADY is seen high, and an
  // idle cycle follows so no signal is assigned twice in one time step.
  task automatic xfer(input logic wr, input dpr_addr_t a, input dpr_word_t d,
                      output dpr_word_t rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= wr ? strb_mode : 4'h0;
    dbg <= dbg_mode;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      conclude();
    end
    @(posedge clk);
  endtask : xfer

  task automatic wr(input dpr_addr_t a, input dpr_word_t d);
    dpr_word_t rd;
    logic err;
    xfer(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd_chk(input dpr_addr_t a, input dpr_word_t exp);
    dpr_word_t rd;
    logic err;
    xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask : rd_chk

  // Bounded wait for the acknowledges to settle at a level.
  task automatic wait_ack(input logic [ND-1:0] exp);
    int n;
    n = 0;
    while (pwr_ack !== exp && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(pwr_ack), 32'(exp));
  endtask : wait_ack

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; on-chip writes made while locked are checked to be dropped
  // silently, while writes from the debug port pass through the lock.
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(pwr_req), 32'h0);
    rd_chk(`DPR_OFS_LOCK_STATUS, 32'h3);
    rd_chk(`DPR_OFS_CLAIM_CLR, 32'h0);
    rd_chk(`DPR_OFS_CLAIM_SET, 32'hf);
    wr(`DPR_OFS_CLAIM_SET, 32'hf);
    rd_chk(`DPR_OFS_CLAIM_CLR, 32'h0);
    dbg_mode = 1'b1;
    wr(`DPR_OFS_CLAIM_SET, 32'h5);
    rd_chk(`DPR_OFS_CLAIM_CLR, 32'h5);
    rd_chk(`DPR_OFS_LOCK_STATUS, 32'h0);
    wr(`DPR_OFS_LOCK_KEY, `DPR_UNLOCK_KEY);
    dbg_mode = 1'b0;
    rd_chk(`DPR_OFS_LOCK_STATUS, 32'h3);
    wr(`DPR_OFS_LOCK_KEY, `DPR_UNLOCK_KEY);
    rd_chk(`DPR_OFS_LOCK_STATUS, 32'h1);
    wr(`DPR_OFS_CLAIM_SET, 32'ha);
    rd_chk(`DPR_OFS_CLAIM_CLR, 32'hf);
    wr(`DPR_OFS_CLAIM_CLR, 32'h3);
    rd_chk(`DPR_OFS_CLAIM_CLR, 32'hc);
    rd_chk(`DPR_OFS_CLAIM_SET, 32'hf);
    rd_chk(`DPR_OFS_INTEG_CTRL, 32'h0);
    chk(32'(integ_mode), 32'h0);
    wr(`DPR_OFS_INTEG_CTRL, 32'hffffffff);
    rd_chk(`DPR_OFS_INTEG_CTRL, 32'h1);
    chk(32'(integ_mode), 32'h1);
    wr(`DPR_OFS_INTEG_CTRL, 32'h0);
    rd_chk(`DPR_OFS_INTEG_CTRL, 32'h0);
    chk(32'(integ_mode), 32'h0);
    // Only the configured domains may show up in the acknowledge view.
    wr(`DPR_OFS_PWR_REQ, 32'hff);
    wait_ack(6'h3f);
    rd_chk(`DPR_OFS_PWR_ACK, 32'h3f);
    // A stalled powerdown must not be overtaken by a new powerup request.
    hold <= 1'b1;
    wr(`DPR_OFS_PWR_REQ, 32'h0);
    // The guard moves one edge after the register, so look one edge later.
    @(posedge clk);
    chk(32'(pwr_req), 32'h0);
    rd_chk(`DPR_OFS_PWR_ACK, 32'h3f);
    wr(`DPR_OFS_PWR_REQ, 32'h15);
    @(posedge clk);
    chk(32'(pwr_req), 32'h0);
    hold <= 1'b0;
    wait_ack(6'h15);
    chk(32'(pwr_req), 32'h15);
    rd_chk(`DPR_OFS_PWR_REQ, 32'h15);
    rd_chk(`DPR_OFS_PWR_ACK, 32'h15);
    // Unmapped address answers with an error and zero data.
    xfer(1'b0, 12'h008, 32'h0, rdv, errv);
    chk(32'(errv), 32'h1);
    chk(rdv, 32'h0);
    wr(`DPR_OFS_LOCK_KEY, 32'hc5acce54);
    rd_chk(`DPR_OFS_LOCK_STATUS, 32'h3);
    // The key only counts as a full word; three lanes keep the lock shut.
    strb_mode = 4'h7;
    wr(`DPR_OFS_LOCK_KEY, `DPR_UNLOCK_KEY);
    strb_mode = 4'hf;
    rd_chk(`DPR_OFS_LOCK_STATUS, 32'h3);
    wr(`DPR_OFS_CLAIM_CLR, 32'hf);
    rd_chk(`DPR_OFS_CLAIM_CLR, 32'hc);
    wr(`DPR_OFS_PWR_REQ, 32'h0);
    rd_chk(`DPR_OFS_PWR_ACK, 32'h15);
    conclude();
  end
endmodule : tb_top
